// [rtl/sccc_top.sv]
module sccc_top
    import sccc_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic stagger_in,
    input wire logic [1:0] run_in,
    input wire logic [3:0] clksel_in,
    input wire logic [2*PRE_W-1:0] prescale_in,
    input wire logic neighbour_overflow_timer_in,
    input wire logic ext_count_in,
    input wire logic [2*TW-1:0] reload_in,
    input wire logic [NUM_CH*3-1:0] mode_in,
    input wire logic [NUM_CH-1:0] tb_sel_in,
    input wire logic [NUM_CH*2-1:0] edge_in,
    input wire logic [NUM_CH/2-1:0] dbl_in,
    input wire logic [NUM_CH-1:0] single_in,
    input wire logic [NUM_CH-1:0] wr_in,
    input wire logic [TW-1:0] wr_data_in,
    input wire logic [NUM_CH-1:0] pin_in,
    output logic [NUM_CH-1:0] pin_out,
    output logic [NUM_CH-1:0] pin_oe_out,
    output logic [NUM_CH*TW-1:0] ccreg_out,
    output logic [NUM_CH-1:0] irq_out,
    output logic [1:0] ovf_out,
    output logic [2*TW-1:0] count_out
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [NUM_CH-1:0] pin_s1_r, pin_s2_r, pin_d_r;
    logic [1:0] aux_s1_r, aux_s2_r, aux_d_r;

    // Channel pins
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_d_r <= '0;
        end else begin
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end

    // External and neighbour count inputs
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            aux_s1_r <= '0;
            aux_s2_r <= '0;
            aux_d_r <= '0;
        end else begin
            aux_s1_r <= {ext_count_in, neighbour_overflow_timer_in};
            aux_s2_r <= aux_s1_r;
            aux_d_r <= aux_s2_r;
        end
    end

    logic nb_evt, ext_evt;
    assign nb_evt = aux_s2_r[0] && !aux_d_r[0];
    assign ext_evt = aux_s2_r[1] && !aux_d_r[1];

    // ****************************************
    // Stagger divider
    // ****************************************
    logic [2:0] stag_r;
    logic slot_en;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            stag_r <= '0;
        end else begin
            stag_r <= stag_r + 3'h1;
        end
    end

    assign slot_en = !stagger_in || (stag_r == STAG_LAST);

    // ****************************************
    // Time bases
    // ****************************************
    sccc_tb_if tbi [2] ();
    logic [TW-1:0] t_count [2];
    logic [1:0] t_tick, t_ovf;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tb
            logic [7:0] pre_r;
            logic pre_en, cnt_en;
            logic [PRE_W-1:0] psel;
            sccc_clksel_t csel;
            assign psel = prescale_in[g*PRE_W +: PRE_W];
            assign csel = sccc_clksel_t'(clksel_in[g*2 +: 2]);

            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    pre_r <= '0;
                end else if (slot_en) begin
                    pre_r <= pre_r + 8'h01;
                end
            end

            // Prescaler enable at 2^psel slots
            assign pre_en = slot_en && ((pre_r & ((8'h01 << psel) - 8'h01)) == 8'h00);

            always_comb begin
                unique case (csel)
                    SCCC_CLK_NEIGHBOUR: cnt_en = nb_evt;
                    SCCC_CLK_EXTERNAL: cnt_en = (g == 0) ? ext_evt : pre_en;
                    default: cnt_en = pre_en;
                endcase
            end

            sccc_timebase u_tb (
                .clk_in(clk_in),
                .nrst_in(nrst_in),
                .run_in(run_in[g]),
                .count_en_in(cnt_en),
                .reload_in(reload_in[g*TW +: TW]),
                .tb(tbi[g])
            );

            assign t_count[g] = tbi[g].count;
            assign t_tick[g] = tbi[g].tick;
            assign t_ovf[g] = tbi[g].ovf;
            assign ovf_out[g] = t_ovf[g];
            assign count_out[g*TW +: TW] = t_count[g];
        end
    endgenerate

    // ****************************************
    // Channel match detection
    // ****************************************
    logic [NUM_CH-1:0] match, ovf_ch, cap_evt;
    logic [TW-1:0] cc_r [NUM_CH];
    logic [NUM_CH-1:0] armed_r, done_r, pin_r, irq_r;

    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            sccc_mode_t md;
            sccc_edge_t ed;
            logic [TW-1:0] tv;
            logic tk, rise, fall;
            assign md = sccc_mode_t'(mode_in[g*3 +: 3]);
            assign ed = sccc_edge_t'(edge_in[g*2 +: 2]);
            assign tv = t_count[tb_sel_in[g]];
            assign tk = t_tick[tb_sel_in[g]];
            assign ovf_ch[g] = t_ovf[tb_sel_in[g]];
            assign rise = pin_s2_r[g] && !pin_d_r[g];
            assign fall = !pin_s2_r[g] && pin_d_r[g];
            assign cap_evt[g] = (md == SCCC_CAP) && slot_en &&
                ((rise && ed[0]) || (fall && ed[1]));
            // Compare once per timer tick so a stopped count does not rematch
            assign match[g] = (md >= SCCC_CMP0) && (md <= SCCC_CMP3) && tk &&
                (tv == cc_r[g]) && armed_r[g];
        end
    endgenerate

    // ****************************************
    // Channel state
    // ****************************************
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_st
            sccc_mode_t md;
            logic pair_tgl, pair_oe;
            assign md = sccc_mode_t'(mode_in[g*3 +: 3]);
            // Upper channel of a pair in double mode also toggles the lower pin, except when the lower channel is in SCCC_CMP3
            if (g < NUM_CH/2) begin : g_lo
                assign pair_tgl = dbl_in[g] && match[g + NUM_CH/2];
                assign pair_oe = dbl_in[g];
            end else begin : g_hi
                assign pair_tgl = 1'b0;
                assign pair_oe = 1'b0;
            end

            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    cc_r[g] <= '0;
                end else if (wr_in[g]) begin
                    cc_r[g] <= wr_data_in;
                end else if (cap_evt[g]) begin
                    cc_r[g] <= t_count[tb_sel_in[g]];
                end
            end

            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    armed_r[g] <= 1'b1;
                end else if (wr_in[g]) begin
                    armed_r[g] <= 1'b1;
                end else if (match[g] && single_in[g]) begin
                    armed_r[g] <= 1'b0;
                end
            end

            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    done_r[g] <= 1'b0;
                end else if (match[g] && ((md == SCCC_CMP2) || (md == SCCC_CMP3))) begin
                    done_r[g] <= 1'b1;
                end else if (ovf_ch[g]) begin
                    done_r[g] <= 1'b0;
                end
            end

            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    pin_r[g] <= 1'b0;
                end else if (md == SCCC_CMP1 && !(dbl_in[g % (NUM_CH/2)] && g >= NUM_CH/2)) begin
                    pin_r[g] <= pin_r[g] ^ match[g] ^ pair_tgl;
                end else if (md == SCCC_CMP3) begin
                    if (match[g] && !done_r[g]) begin
                        pin_r[g] <= 1'b1;
                    end else if (ovf_ch[g]) begin
                        pin_r[g] <= 1'b0;
                    end
                end else if (pair_tgl) begin
                    pin_r[g] <= !pin_r[g];
                end
            end

            always_ff @(posedge clk_in) begin
                if (!nrst_in) begin
                    irq_r[g] <= 1'b0;
                end else begin
                    irq_r[g] <= cap_evt[g] ||
                        (match[g] && (md != SCCC_CMP2) && (md != SCCC_CMP3)) ||
                        (match[g] && !done_r[g]);
                end
            end

            assign pin_oe_out[g] = ((md >= SCCC_CMP1) && (md != SCCC_CMP2)) || pair_oe;
            assign ccreg_out[g*TW +: TW] = cc_r[g];
        end
    endgenerate

    assign pin_out = pin_r;
    assign irq_out = irq_r;
endmodule // sccc_top

// [rtl/sccc_pkg.sv]
package sccc_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_CH = 16;
    localparam int TW = 16;
    localparam int PRE_W = 3;
    localparam int STAGGER_DIV = 8;
    localparam logic [TW-1:0] RELOAD_RST = 16'h0000;
    localparam logic [TW-1:0] TIMER_MAX = 16'hffff;
    localparam logic [2:0] STAG_LAST = 3'h7;

    // ****************************************
    // Encodings
    // ****************************************
    typedef enum logic [2:0] {
        SCCC_OFF, SCCC_CAP, SCCC_CMP0, SCCC_CMP1, SCCC_CMP2, SCCC_CMP3
    } sccc_mode_t;

    typedef enum logic [1:0] {
        SCCC_EDGE_NONE, SCCC_EDGE_RISE, SCCC_EDGE_FALL, SCCC_EDGE_BOTH
    } sccc_edge_t;

    typedef enum logic [1:0] {
        SCCC_CLK_PRESCALE, SCCC_CLK_NEIGHBOUR, SCCC_CLK_EXTERNAL
    } sccc_clksel_t;
endpackage

// [rtl/sccc_tb_if.sv]
// ****************************************
// Time base bundle between timer and channel array
// ****************************************
interface sccc_tb_if;
    import sccc_pkg::*;
    logic [TW-1:0] count;
    logic tick;
    logic ovf;
    modport src (output count, output tick, output ovf);
    modport snk (input count, input tick, input ovf);
endinterface

// [rtl/sccc_timebase.sv]
module sccc_timebase
    import sccc_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic run_in,
    input wire logic count_en_in,
    input wire logic [TW-1:0] reload_in,
    sccc_tb_if.src tb
);
    logic [TW-1:0] count_r;
    logic ovf_r;

    // ****************************************
    // Counter with reload on overflow
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            count_r <= RELOAD_RST;
        end else if (run_in && count_en_in) begin
            if (count_r == TIMER_MAX) begin
                count_r <= reload_in;
            end else begin
                count_r <= count_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ovf_r <= 1'b0;
        end else begin
            ovf_r <= run_in && count_en_in && (count_r == TIMER_MAX);
        end
    end

    assign tb.count = count_r;
    assign tb.tick = run_in && count_en_in;
    assign tb.ovf = ovf_r;
endmodule // sccc_timebase

// [tb/sccc_pin_model.sv]
module sccc_pin_model (
    input logic [15:0] pin_out,
    input logic [15:0] pin_oe_out,
    output logic [15:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Outside signals on the channel pins
    // ****************************************
    logic [15:0] ext_r = 16'h0000;
    // A driven pin reads back its own level
    assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & ext_r);
    task automatic drive(input int ch, input logic v);
        ext_r[ch] = v;
    endtask
endmodule // sccc_pin_model

// [tb/sccc_top_chk.sv]
module sccc_top_chk
    import sccc_pkg::*;
(
    input logic clk_in,
    input logic nrst_in,
    input logic [1:0] run_in,
    input logic [3:0] clksel_in,
    input logic [5:0] prescale_in,
    input logic [47:0] mode_in,
    input logic [31:0] edge_in,
    input logic [7:0] dbl_in,
    input logic [15:0] pin_in,
    input logic [15:0] pin_out,
    input logic [15:0] pin_oe_out,
    input logic [15:0] irq_out,
    input logic [1:0] ovf_out,
    input logic [31:0] count_out
);
    // ****************************************
    // Port checks
    // ****************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic [1:0] n2_r;
    always_ff @(posedge clk_in) begin
        if (!nrst_in || ovf_out[0] || mode_in[8:6] != SCCC_CMP2) begin
            n2_r <= 2'h0;
        end else if (irq_out[2] && n2_r != 2'h3) begin
            n2_r <= n2_r + 2'h1;
        end
    end
    cnt_step_a: assert property ((run_in[0] && clksel_in[1:0] == 2'h0 && prescale_in[2:0] == 3'h0
        && count_out[15:0] != 16'hffff)[*3] |=> count_out[15:0] == $past(count_out[15:0]) + 16'h1)
        else $error("count did not step");
    ovf_wrap_a: assert property (ovf_out[0] |-> $past(count_out[15:0]) == 16'hffff
        || $past(count_out[15:0], 2) == 16'hffff) else $error("overflow without wrap");
    off_quiet_a: assert property ((mode_in[2:0] == SCCC_OFF)[*2] |-> !irq_out[0])
        else $error("request from idle channel");
    oe_map_a: assert property (pin_oe_out[8] == (mode_in[26:24] == SCCC_CMP1 || mode_in[26:24] == SCCC_CMP3))
        else $error("pin enable wrong");
    keep_pin_a: assert property ((mode_in[29:27] == SCCC_CMP0)[*2] |=> $stable(pin_out[9]))
        else $error("pin moved in mode 0");
    cmp2_once_a: assert property (n2_r <= 2'h1) else $error("second mode 2 request");
    cmp3_clr_a: assert property (ovf_out[0] && mode_in[11:9] == SCCC_CMP3 |-> ##[0:1] !pin_out[3])
        else $error("mode 3 pin not cleared");
    toggle_why_a: assert property ($changed(pin_out[1]) |-> $past(mode_in[5:3]) == SCCC_CMP1
        || $past(mode_in[5:3]) == SCCC_CMP3 || $past(dbl_in[1])) else $error("pin toggled idle");
    cap_irq_a: assert property ($rose(pin_in[5]) && mode_in[17:15] == SCCC_CAP && edge_in[10]
        |-> ##[1:4] irq_out[5]) else $error("no capture request");
    cover property (ovf_out[0]);
    cover property (irq_out[5]);
    cover property ($changed(pin_out[0]));
endmodule // sccc_top_chk

bind sccc_top sccc_top_chk chk_i (.clk_in, .nrst_in, .run_in, .clksel_in, .prescale_in, .mode_in, .edge_in,
    .dbl_in, .pin_in, .pin_out, .pin_oe_out, .irq_out, .ovf_out, .count_out);

// [tb/tb.sv]
module tb
    import sccc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Bench
    // ****************************************
    logic clk_in = 1'b0, nrst_in = 1'b0, stagger_in = 1'b0, neighbour_overflow_timer_in = 1'b0, ext_count_in = 1'b0;
    logic [1:0] run_in = '0, ovf_out;
    logic [3:0] clksel_in = '0;
    logic [5:0] prescale_in = '0;
    logic [31:0] reload_in = '0, edge_in = '0, count_out;
    logic [47:0] mode_in = '0;
    logic [7:0] dbl_in = '0;
    logic [15:0] tb_sel_in = '0, single_in = '0, wr_in = '0, wr_data_in = '0, pin_in, pin_out, pin_oe_out, irq_out;
    logic [15:0] prev_pin = '0;
    logic [15:0] mark = '0;
    logic [255:0] ccreg_out;
    int fail_count = 0, total_checks = 0, cycles = 0;
    int ev[17], tg[16];
    int chs[7] = '{0, 1, 2, 3, 4, 8, 9};
    logic [15:0] vals[7] = '{16'hfff2, 16'hfff4, 16'hfff6, 16'hfffa, 16'hfff3, 16'hfffc, 16'hfff8};
    sccc_top uut (.clk_in, .nrst_in, .stagger_in, .run_in, .clksel_in, .prescale_in, .neighbour_overflow_timer_in,
        .ext_count_in, .reload_in, .mode_in, .tb_sel_in, .edge_in, .dbl_in, .single_in, .wr_in, .wr_data_in,
        .pin_in, .pin_out, .pin_oe_out, .ccreg_out, .irq_out, .ovf_out, .count_out);
    sccc_pin_model pm (.pin_out, .pin_oe_out, .pin_in);
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // Event tally per channel, overflow in the last slot
    always @(posedge clk_in) begin
        cycles++;
        for (int i = 0; i < 16; i++) begin
            ev[i] += int'(irq_out[i] === 1'b1);
            tg[i] += int'(pin_out[i] !== prev_pin[i]);
        end
        ev[16] += int'(ovf_out[0] === 1'b1);
        prev_pin = pin_out;
        if (cycles == 90000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic clr();
        ev = '{default: 0};
        tg = '{default: 0};
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input int ch, input logic [15:0] v);
        wr_data_in = v;
        wr_in = 16'h0001 << ch;
        cyc(1);
        wr_in = '0;
        cyc(1);
    endtask
    task automatic pulse(input int which, input int n);
        repeat (n) begin
            if (which == 0) ext_count_in = 1'b1;
            else neighbour_overflow_timer_in = 1'b1;
            cyc(3);
            ext_count_in = 1'b0;
            neighbour_overflow_timer_in = 1'b0;
            cyc(3);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        cyc(10);
        nrst_in = 1'b1;
        clksel_in = 4'h2;
        run_in = 2'h1;
        cyc(2);
        pulse(0, 3);
        chk(count_out[15:0], 16'h0003);
        clksel_in = 4'h0;
        reload_in[15:0] = 16'hfff0;
        mode_in = {15'h0000, SCCC_CMP0, SCCC_CMP0, SCCC_CMP0, 9'h000,
            SCCC_CMP1, SCCC_CMP3, SCCC_CMP2, SCCC_CMP1, SCCC_CMP1};
        dbl_in[0] = 1'b1;
        single_in[4] = 1'b1;
        foreach (chs[i]) wr(chs[i], vals[i]);
        while (ovf_out[0] !== 1'b1) cyc(1);
        clr();
        wr(4, 16'hfff3);
        cyc(46);
        chk(16'(ev[16]), 16'h0003);
        chk(16'(ev[9]), 16'h0003);
        chk(16'(tg[9]), 16'h0000);
        chk(16'(tg[1]), 16'h0003);
        chk(16'(tg[0]), 16'h0006);
        chk(16'(tg[3]), 16'h0006);
        chk(16'(tg[4]), 16'h0001);
        chk(16'(ev[2]), 16'h0003);
        while (count_out[15:0] !== 16'hffff) cyc(1);
        chk(16'(pin_out[3]), 16'h0001);
        cyc(3);
        chk(16'(pin_out[3]), 16'h0000);
        while (irq_out[2] !== 1'b1) cyc(1);
        wr(2, 16'hfffd);
        clr();
        while (ovf_out[0] !== 1'b1) cyc(1);
        chk(16'(ev[2]), 16'h0000);
        for (int c = 5; c < 8; c++) begin
            mode_in[c*3+:3] = SCCC_CAP;
            edge_in[c*2+:2] = 2'(c - 4);
            cyc(2);
            clr();
            pm.drive(c, 1'b1);
            cyc(6);
            chk(16'(ev[c]), 16'((c - 4) & 1));
            chk(16'(ccreg_out[c*16+:16] >= 16'hfff0), 16'(c != 6));
            clr();
            pm.drive(c, 1'b0);
            cyc(6);
            chk(16'(ev[c]), 16'((c - 4) >> 1));
        end
        mode_in[32:30] = SCCC_CMP0;
        tb_sel_in[10] = 1'b1;
        wr(10, 16'h0002);
        clksel_in[3:2] = 2'h1;
        run_in[1] = 1'b1;
        clr();
        cyc(8);
        chk(16'(ev[10]), 16'h0000);
        pulse(1, 3);
        chk(count_out[31:16], 16'h0003);
        chk(16'(ev[10]), 16'h0001);
        run_in[0] = 1'b0;
        clksel_in[3:2] = 2'h0;
        stagger_in = 1'b1;
        mark = count_out[31:16];
        cyc(16);
        chk(count_out[31:16] - mark, 16'h0002);
        stagger_in = 1'b0;
        prescale_in[5:3] = 3'h2;
        mark = count_out[31:16];
        cyc(16);
        chk(count_out[31:16] - mark, 16'h0004);
        close_out();
    end
endmodule // tb
